// ==== hw/pfint_ctrl.sv ====
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - Fault inputs grouped by seven, one vector
// - Group level fixed at build time
// - First group enable at byte 7Eh
// - Group enable low blocks all seven
// - Group enable low blocks group wakeup
// - Request needs source, source enable, group enable
// - Group flag sets on enabled active source
// - Flag clears on written 0 only
// - Status bits live, read-only, unlatched
// - Acknowledge with nothing pending gives phantom vector
// - Highest priority first, chain order, mask gated
// - Service entry sets mask to all ones
// - Further nonmaskables ignored until return; one in the acknowledge cycle is held
// - Return pops saved mask level
// - Recognition always uses current mask level
// - Nonmaskable and polarity bits freezable independently
// - Frozen nonmaskable select forces mode
// - Frozen polarity forces edge direction
// - Polarity 0 falling, 1 rising
// - Nonmaskable select 1 routes pin as nonmaskable
module pfint_ctrl #(
    parameter logic [2:0] GROUP_LEVEL   = pfint_pkg::LEVEL_PF_DEF,
    parameter logic       FREEZE_NMI    = 1'b0,
    parameter logic       FREEZE_NMI_TO = 1'b0,
    parameter logic       FREEZE_POL    = 1'b0,
    parameter logic       FREEZE_POL_TO = 1'b0
) (
    // Clock and reset
    input  wire logic                                                  i_sys_clk,
    input  wire logic                                                  i_rst_n,
    // Register port
    input  wire logic [7:0]                                            i_addr,
    input  wire logic [7:0]                                            i_wdata,
    input  wire logic                                                  i_wr,
    input  wire logic                                                  i_rd,
    output logic      [7:0]                                            o_rdata,
    // Fault sources and external pin
    input  wire logic [pfint_pkg::NUM_GROUPS*pfint_pkg::SRC_PER_GRP-1:0] i_fault,
    input  wire logic                                                  i_ext_pin,
    // CPU side
    input  wire logic                                                  i_iack,
    input  wire logic                                                  i_rti,
    output logic                                                       o_irq,
    output logic                                                       o_nmi,
    output logic                                                       o_vec_valid,
    output logic      [15:0]                                           o_vector,
    output logic      [2:0]                                            o_mask_level,
    output logic      [pfint_pkg::NUM_GROUPS-1:0]                      o_wakeup
);
    import pfint_pkg::*;

    //////////////////////////////////////////////////////////////////////
    // Declarations
    logic [6:0]             src_en_ff     [NUM_GROUPS];
    logic [NUM_GROUPS-1:0]  grp_en_ff;
    logic [NUM_GROUPS-1:0]  grp_flag_ff;
    logic [6:0]             sts           [NUM_GROUPS];
    logic [NUM_GROUPS-1:0]  grp_hit;
    logic [NUM_GROUPS-1:0]  grp_req;
    logic [NUM_GROUPS-1:0]  wr_en_sel;
    logic [NUM_GROUPS-1:0]  wr_flag_sel;
    logic                   a_nmi_sw_ff;
    logic                   a_pol_sw_ff;
    logic                   a_prio_ff;
    logic                   a_enable_ff;
    logic                   a_flag_ff;
    logic                   a_pend_ff;
    logic                   nmi_pend_ff;
    logic                   nmi_active_ff;
    logic [2:0]             pin_sync_ff;
    logic                   pin_level_ff;
    logic                   a_nmi_eff;
    logic                   a_pol_eff;
    logic                   pin_change;
    logic                   a_edge;
    logic [2:0]             a_level;
    logic                   a_ok;
    logic [2:0]             mask_ff;
    logic [2:0]             mask_stack_ff [STACK_DEPTH];
    logic [STACK_PTR_W-1:0] sp_ff;
    logic                   take_nmi;
    logic                   any_ok;
    logic [15:0]            nxt_vector;
    logic                   nxt_irq;
    logic                   clr_a_flag;

    //////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Byte address of a group's enable register
    function automatic logic [7:0] enable_addr(input int g);
        enable_addr = ADDR_PF_ENABLE_G1 - 8'(g) * ADDR_GROUP_STRIDE;
    endfunction

    // Byte address of a group's flag register
    function automatic logic [7:0] flag_addr(input int g);
        flag_addr = ADDR_PF_FLAG_G1 - 8'(g) * ADDR_GROUP_STRIDE;
    endfunction

    // Recognition test against current mask; mask 7 blocks everything
    function automatic logic above_mask(input logic [2:0] lvl, input logic [2:0] msk);
        above_mask = (lvl > msk);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // Power-fault groups
    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            sts[g]         = i_fault[g*SRC_PER_GRP +: SRC_PER_GRP];
            grp_hit[g]     = |(sts[g] & src_en_ff[g]);
            grp_req[g]     = grp_en_ff[g] & grp_hit[g];
            wr_en_sel[g]   = i_wr && (i_addr == enable_addr(g));
            wr_flag_sel[g] = i_wr && (i_addr == flag_addr(g));
        end
    end

    // Enable registers, cleared at reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                src_en_ff[g] <= RST_PF_ENABLE[6:0];
                grp_en_ff[g] <= RST_PF_ENABLE[BIT_GROUP_EN];
            end
        end else begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (wr_en_sel[g]) begin
                    src_en_ff[g] <= i_wdata[6:0];
                    grp_en_ff[g] <= i_wdata[BIT_GROUP_EN];
                end
            end
        end
    end

    // Sticky group flag; a new hit beats a clearing write in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            grp_flag_ff <= {NUM_GROUPS{RST_FLAG}};
        end else begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (grp_hit[g]) begin
                    grp_flag_ff[g] <= 1'b1;
                end else if (wr_flag_sel[g] && !i_wdata[BIT_GROUP_FLAG]) begin
                    grp_flag_ff[g] <= 1'b0;
                end
            end
        end
    end

    // Wakeup follows the gated request, so group disable kills it too
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_wakeup <= '0;
        end else begin
            o_wakeup <= grp_req;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Type A pin: three-stage sync, change accepted when stages 2 and 3 agree
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pin_sync_ff  <= 3'h0;
            pin_level_ff <= 1'b0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], i_ext_pin};
            if (pin_sync_ff[1] == pin_sync_ff[2]) begin
                pin_level_ff <= pin_sync_ff[2];
            end
        end
    end

    // Frozen bits override software copies; the other bit stays writable
    assign a_nmi_eff  = FREEZE_NMI ? FREEZE_NMI_TO : a_nmi_sw_ff;
    assign a_pol_eff  = FREEZE_POL ? FREEZE_POL_TO : a_pol_sw_ff;
    assign pin_change = (pin_sync_ff[1] == pin_sync_ff[2]) && (pin_sync_ff[2] != pin_level_ff);
    assign a_edge     = pin_change && (pin_sync_ff[2] == a_pol_eff);
    assign a_level    = a_prio_ff ? LEVEL_A_LOW : LEVEL_A_HIGH;
    assign clr_a_flag = i_wr && (i_addr == ADDR_TYPEA_FLAG) && !i_wdata[BIT_A_FLAG];

    // Type A control register; writes to frozen bits land in unused copies
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            a_nmi_sw_ff <= 1'b0;
            a_pol_sw_ff <= 1'b0;
            a_prio_ff   <= 1'b0;
            a_enable_ff <= 1'b0;
        end else if (i_wr && (i_addr == ADDR_TYPEA_CTRL)) begin
            a_nmi_sw_ff <= i_wdata[BIT_A_NMI];
            a_pol_sw_ff <= i_wdata[BIT_A_POL];
            a_prio_ff   <= i_wdata[BIT_A_PRIO];
            a_enable_ff <= i_wdata[BIT_A_ENABLE];
        end
    end

    // Type A flag and pending requests; the edge wins over a clear
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            a_flag_ff   <= RST_FLAG;
            a_pend_ff   <= 1'b0;
            nmi_pend_ff <= 1'b0;
        end else begin
            if (a_edge) begin
                a_flag_ff <= 1'b1;
            end else if (clr_a_flag) begin
                a_flag_ff <= 1'b0;
            end
            // Maskable request: one per edge, dropped by flag clear or service
            if (a_edge && !a_nmi_eff && a_enable_ff) begin
                a_pend_ff <= 1'b1;
            end else if (clr_a_flag || (i_iack && !take_nmi && a_ok)) begin
                a_pend_ff <= 1'b0;
            end
            // Nonmaskable request while not already in a nonmaskable routine
            if (a_edge && a_nmi_eff && !nmi_active_ff) begin
                nmi_pend_ff <= 1'b1;
            end else if (i_iack && take_nmi) begin
                nmi_pend_ff <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Priority chain: nonmaskable, then Type A, then groups in order
    assign take_nmi = nmi_pend_ff && !nmi_active_ff;
    assign a_ok     = a_pend_ff && above_mask(a_level, mask_ff);

    always_comb begin
        any_ok     = 1'b0;
        nxt_vector = VEC_PHANTOM;
        if (take_nmi) begin
            any_ok     = 1'b1;
            nxt_vector = VEC_NMI;
        end else if (a_ok) begin
            any_ok     = 1'b1;
            nxt_vector = VEC_TYPEA;
        end else begin
            for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
                if (grp_req[g] && above_mask(GROUP_LEVEL, mask_ff)) begin
                    any_ok     = 1'b1;
                    nxt_vector = VEC_PF_BASE + 16'(g) * VEC_STEP;
                end
            end
        end
        nxt_irq = any_ok && !take_nmi;
    end

    //////////////////////////////////////////////////////////////////////
    // Mask level with save stack; an overflowing nest drops its own save and keeps the four older entries
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            mask_ff       <= RST_MASK;
            sp_ff         <= '0;
            nmi_active_ff <= 1'b0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                mask_stack_ff[i] <= RST_MASK;
            end
        end else if (i_iack) begin
            mask_ff <= MASK_ALL;
            if (sp_ff < STACK_PTR_W'(STACK_DEPTH)) begin
                mask_stack_ff[sp_ff[1:0]] <= mask_ff;
                sp_ff                     <= sp_ff + 1'b1;
            end
            if (take_nmi) begin
                nmi_active_ff <= 1'b1;
            end
        end else if (i_rti) begin
            if (sp_ff != '0) begin
                mask_ff <= mask_stack_ff[2'(sp_ff - 1'b1)];
                sp_ff   <= sp_ff - 1'b1;
            end
            nmi_active_ff <= 1'b0;
        end else if (i_wr && (i_addr == ADDR_MASK_LEVEL)) begin
            mask_ff <= i_wdata[2:0];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // CPU outputs: request levels and vector answer one cycle after acknowledge
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_irq        <= 1'b0;
            o_nmi        <= 1'b0;
            o_vec_valid  <= 1'b0;
            o_vector     <= VEC_PHANTOM;
            o_mask_level <= RST_MASK;
        end else begin
            o_irq        <= nxt_irq && !i_iack;
            o_nmi        <= take_nmi && !i_iack;
            o_vec_valid  <= i_iack;
            o_mask_level <= mask_ff;
            if (i_iack) begin
                o_vector <= nxt_vector;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Read port: data only in the cycle after the strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= 8'h00;
            if (i_rd) begin
                if (i_addr == ADDR_TYPEA_CTRL) begin
                    o_rdata <= {1'b0, pin_level_ff, a_nmi_eff, 2'b00, a_pol_eff, a_prio_ff, a_enable_ff};
                end else if (i_addr == ADDR_TYPEA_FLAG) begin
                    o_rdata <= {a_flag_ff, 7'h00};
                end else if (i_addr == ADDR_MASK_LEVEL) begin
                    o_rdata <= {2'b00, sp_ff, mask_ff};
                end
                for (int g = 0; g < NUM_GROUPS; g++) begin
                    if (i_addr == enable_addr(g)) begin
                        o_rdata <= {grp_en_ff[g], src_en_ff[g]};
                    end else if (i_addr == flag_addr(g)) begin
                        o_rdata <= {grp_flag_ff[g], sts[g]};
                    end
                end
            end
        end
    end

endmodule

// ==== shared/pfint_pkg.sv ====
package pfint_pkg;

    //////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_GROUPS  = 2;
    localparam int SRC_PER_GRP = 7;
    localparam int STACK_DEPTH = 4;
    localparam int STACK_PTR_W = 3;

    //////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] ADDR_TYPEA_CTRL   = 8'h70;
    localparam logic [7:0] ADDR_TYPEA_FLAG   = 8'h71;
    localparam logic [7:0] ADDR_MASK_LEVEL   = 8'h60;
    localparam logic [7:0] ADDR_PF_ENABLE_G1 = 8'h7E;
    localparam logic [7:0] ADDR_PF_FLAG_G1   = 8'h7F;
    localparam logic [7:0] ADDR_GROUP_STRIDE = 8'h02;

    //////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_GROUP_EN   = 7;
    localparam int BIT_GROUP_FLAG = 7;
    localparam int BIT_A_PIN      = 6;
    localparam int BIT_A_NMI      = 5;
    localparam int BIT_A_POL      = 2;
    localparam int BIT_A_PRIO     = 1;
    localparam int BIT_A_ENABLE   = 0;
    localparam int BIT_A_FLAG     = 7;

    //////////////////////////////////////////////////////////////////////
    // Reset values and full mask
    localparam logic [7:0] RST_PF_ENABLE = 8'h00;
    localparam logic       RST_FLAG      = 1'b0;
    localparam logic [2:0] RST_MASK      = 3'h0;
    localparam logic [2:0] MASK_ALL      = 3'h7;

    //////////////////////////////////////////////////////////////////////
    // Levels and vectors
    localparam logic [2:0]  LEVEL_A_HIGH  = 3'h6;
    localparam logic [2:0]  LEVEL_A_LOW   = 3'h3;
    localparam logic [2:0]  LEVEL_PF_DEF  = 3'h5;
    localparam logic [15:0] VEC_PHANTOM   = 16'h8004;
    localparam logic [15:0] VEC_NMI       = 16'h8006;
    localparam logic [15:0] VEC_TYPEA     = 16'h8008;
    localparam logic [15:0] VEC_PF_BASE   = 16'h800A;
    localparam logic [15:0] VEC_STEP      = 16'h0002;

endpackage

// ==== testbench/pfint_ctrl_assertions.sv ====
`timescale 1ns/1ps
// Watches the controller ports only
module pfint_ctrl_assertions
    import pfint_pkg::*;
(
    // Clock and reset
    input wire logic                                  i_sys_clk,
    input wire logic                                  i_rst_n,
    // Inputs seen by the controller
    input wire logic                                  i_rd,
    input wire logic                                  i_wr,
    input wire logic                                  i_iack,
    input wire logic                                  i_rti,
    input wire logic [NUM_GROUPS*SRC_PER_GRP-1:0]     i_fault,
    // Outputs of the controller
    input wire logic                                  o_irq,
    input wire logic                                  o_nmi,
    input wire logic                                  o_vec_valid,
    input wire logic [15:0]                           o_vector,
    input wire logic [7:0]                            o_rdata,
    input wire logic [2:0]                            o_mask_level,
    input wire logic [NUM_GROUPS-1:0]                 o_wakeup
);
    logic in_nmi_ff;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    //////////////////////////////////////////////////////////////////////
    // Tracks a nonmaskable routine; the pulse on return frees it again
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || i_rti) begin
            in_nmi_ff <= 1'b0;
        end else if (o_vec_valid && o_vector == VEC_NMI) begin
            in_nmi_ff <= 1'b1;
        end
    end

    // Service entry takes two steps: acknowledge, then vector followed by full mask
    sequence ack_taken_s;
        i_iack;
    endsequence
    // The mask copy lags the live mask by one cycle, so full mask shows one cycle after valid
    sequence entry_done_s;
        o_vec_valid && !o_irq && !o_nmi ##1 o_mask_level == MASK_ALL;
    endsequence

    //////////////////////////////////////////////////////////////////////
    service_entry_a: assert property (ack_taken_s |=> entry_done_s)
        else $error("service entry not seen after acknowledge");
    vec_needs_ack_a: assert property (o_vec_valid |-> $past(i_iack))
        else $error("vector without acknowledge");
    vec_hold_a: assert property (!o_vec_valid |-> $stable(o_vector))
        else $error("vector moved without valid");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read answer");
    wake_cause_a: assert property ((o_wakeup[0] -> $past(|i_fault[6:0])) &&
        (o_wakeup[1] -> $past(|i_fault[13:7])))
        else $error("wakeup without active source");
    // Every cause acts on the live mask first, so its copy moves two edges later
    mask_cause_a: assert property (o_mask_level != $past(o_mask_level) |->
        $past(i_iack, 2) || $past(i_rti, 2) || $past(i_wr, 2))
        else $error("mask level moved without cause");
    nmi_block_a: assert property (in_nmi_ff |-> !o_nmi)
        else $error("nonmaskable request inside its own routine");
    masked_irq_a: assert property ($past(o_mask_level) == MASK_ALL && o_mask_level == MASK_ALL |-> !o_irq)
        else $error("maskable request under full mask");
endmodule

bind pfint_ctrl pfint_ctrl_assertions u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_rd(i_rd), .i_wr(i_wr), .i_iack(i_iack),
    .i_rti(i_rti), .i_fault(i_fault), .o_irq(o_irq), .o_nmi(o_nmi), .o_vec_valid(o_vec_valid),
    .o_vector(o_vector), .o_rdata(o_rdata), .o_mask_level(o_mask_level), .o_wakeup(o_wakeup)
);

// ==== testbench/pfint_cpu_model.sv ====
`timescale 1ns/1ps
// CPU stand-in: acknowledges or returns after a chosen delay
module pfint_cpu_model (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // Requests from the bench
    input  wire logic       i_ack_req,
    input  wire logic       i_rti_req,
    input  wire logic [3:0] i_delay,
    // Toward the controller
    output logic            o_iack,
    output logic            o_rti
);
    logic [3:0] cnt_ff;
    logic       pend_ff;
    logic       kind_ff;

    // One-cycle pulses, never both together, so slow and prompt answers both occur
    always_ff @(posedge i_sys_clk) begin
        o_iack <= 1'b0;
        o_rti  <= 1'b0;
        if (!i_rst_n) begin
            pend_ff <= 1'b0;
            kind_ff <= 1'b0;
            cnt_ff  <= 4'h0;
        end else if (i_ack_req || i_rti_req) begin
            pend_ff <= 1'b1;
            kind_ff <= i_rti_req;
            cnt_ff  <= i_delay;
        end else if (pend_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end else if (pend_ff) begin
            pend_ff <= 1'b0;
            o_iack  <= !kind_ff;
            o_rti   <= kind_ff;
        end
    end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import pfint_pkg::*;
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [13:0] i_fault = 14'h0000;
    logic        i_ext_pin = 1'b0;
    logic        ack_req = 1'b0;
    logic        rti_req = 1'b0;
    logic [3:0]  dly = 4'h0;
    logic        i_iack, i_rti, o_irq, o_nmi, o_vec_valid;
    logic [7:0]  o_rdata;
    logic [15:0] o_vector;
    logic [2:0]  o_mask_level;
    logic [1:0]  o_wakeup;
    logic        rd_seen = 1'b0;
    logic [15:0] rq[$];
    logic [15:0] vq[$];
    logic [6:0]  pat;
    logic [7:0]  f_rdata;
    logic        f_nmi;
    int          mismatches = 0;
    int          n_tests = 0;

    always #50 i_sys_clk = ~i_sys_clk;

    pfint_ctrl dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fault(i_fault), .i_ext_pin(i_ext_pin),
        .i_iack(i_iack), .i_rti(i_rti), .o_irq(o_irq), .o_nmi(o_nmi), .o_vec_valid(o_vec_valid),
        .o_vector(o_vector), .o_mask_level(o_mask_level), .o_wakeup(o_wakeup));
    pfint_cpu_model u_cpu (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ack_req(ack_req),
        .i_rti_req(rti_req), .i_delay(dly), .o_iack(i_iack), .o_rti(i_rti));
    // Second copy with both Type A bits frozen: select at 0, polarity at 1
    pfint_ctrl #(.FREEZE_NMI(1'b1), .FREEZE_NMI_TO(1'b0), .FREEZE_POL(1'b1), .FREEZE_POL_TO(1'b1)) dut_frz (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(f_rdata), .i_fault(i_fault), .i_ext_pin(i_ext_pin), .i_iack(i_iack), .i_rti(i_rti), .o_irq(),
        .o_nmi(f_nmi), .o_vec_valid(), .o_vector(), .o_mask_level(), .o_wakeup());

    //////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %0s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Register port: one-cycle strobes, expected read data noted first
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back({8'h00, e});
        @(posedge i_sys_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    // Bounded wait for a request line; a hang ends the run
    task automatic wait_hi(input bit nmi);
        int k;
        k = 0;
        while (((nmi ? o_nmi : o_irq) !== 1'b1) && k < 20) begin
            @(negedge i_sys_clk);
            k++;
        end
        if ((nmi ? o_nmi : o_irq) !== 1'b1) begin
            mismatches++;
            $display("unexpected request wait: expected 1 seen 0");
            end_sim();
        end
    endtask

    // Acknowledge (vector noted) or return, with a random CPU delay
    task automatic cpu(input bit ret, input logic [15:0] v);
        if (!ret) vq.push_back(v);
        @(posedge i_sys_clk);
        dly     <= 4'($urandom_range(3, 0));
        ack_req <= !ret;
        rti_req <= ret;
        @(posedge i_sys_clk);
        ack_req <= 1'b0;
        rti_req <= 1'b0;
        idle(8);
        @(negedge i_sys_clk);
    endtask

    //////////////////////////////////////////////////////////////////////
    // Result watcher: read data the cycle after a strobe, vectors on valid
    always @(posedge i_sys_clk) rd_seen <= i_rd;
    always @(negedge i_sys_clk) begin
        if (rd_seen) begin
            if (rq.size() == 0) chk("read note", 16'h0000, 16'hFFFF);
            else chk("read data", rq.pop_front(), {8'h00, o_rdata});
        end
        if (o_vec_valid === 1'b1) begin
            if (vq.size() == 0) chk("vector note", 16'h0000, o_vector);
            else chk("vector", vq.pop_front(), o_vector);
        end
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        mismatches++;
        $display("unexpected run length: expected end seen hang");
        end_sim();
    end

    initial begin
        pat = 7'($urandom(27924));
        pat = 7'($urandom_range(127, 1));
        idle(3);
        i_rst_n <= 1'b1;
        rd(ADDR_PF_ENABLE_G1, RST_PF_ENABLE);
        rd(ADDR_PF_FLAG_G1, 8'h00);
        rd(ADDR_MASK_LEVEL, 8'h00);
        wr(8'h90, 8'hFF);
        rd(8'h90, 8'h00);
        $display("test reset done");
        wr(ADDR_PF_ENABLE_G1, 8'h7F);
        rd(ADDR_PF_ENABLE_G1, 8'h7F);
        i_fault[6:0] <= pat;
        idle(3);
        @(negedge i_sys_clk);
        chk("irq", 16'h0000, {15'h0000, o_irq});
        chk("wakeup", 16'h0000, {14'h0000, o_wakeup});
        rd(ADDR_PF_FLAG_G1, {1'b1, pat});
        // Sources dropped first, so only the write decides the sticky flag
        i_fault <= 14'h0000;
        idle(2);
        wr(ADDR_PF_FLAG_G1, 8'h80);
        rd(ADDR_PF_FLAG_G1, 8'h80);
        wr(ADDR_PF_FLAG_G1, 8'h00);
        rd(ADDR_PF_FLAG_G1, 8'h00);
        $display("test flags done");
        i_fault[0] <= 1'b1;
        wr(ADDR_PF_ENABLE_G1, 8'hFF);
        wait_hi(1'b0);
        chk("wakeup", 16'h0001, {14'h0000, o_wakeup});
        cpu(1'b0, VEC_PF_BASE);
        chk("mask", 16'h0007, {13'h0000, o_mask_level});
        @(posedge i_sys_clk);
        i_fault[7] <= 1'b1;
        wr(ADDR_PF_ENABLE_G1 - ADDR_GROUP_STRIDE, 8'hFF);
        idle(4);
        @(negedge i_sys_clk);
        chk("irq", 16'h0000, {15'h0000, o_irq});
        chk("wakeup", 16'h0003, {14'h0000, o_wakeup});
        cpu(1'b1, 16'h0000);
        chk("mask", 16'h0000, {13'h0000, o_mask_level});
        wait_hi(1'b0);
        cpu(1'b0, VEC_PF_BASE);
        @(posedge i_sys_clk);
        i_fault[0] <= 1'b0;
        wr(ADDR_MASK_LEVEL, 8'h00);
        wait_hi(1'b0);
        cpu(1'b0, VEC_PF_BASE + VEC_STEP);
        @(posedge i_sys_clk);
        i_fault <= 14'h0000;
        cpu(1'b1, 16'h0000);
        cpu(1'b1, 16'h0000);
        chk("mask", 16'h0000, {13'h0000, o_mask_level});
        cpu(1'b0, VEC_PHANTOM);
        cpu(1'b1, 16'h0000);
        $display("test nesting done");
        wr(ADDR_TYPEA_CTRL, 8'h04);
        i_ext_pin <= 1'b1;
        idle(6);
        rd(ADDR_TYPEA_FLAG, 8'h80);
        wr(ADDR_TYPEA_FLAG, 8'h00);
        wr(ADDR_TYPEA_CTRL, 8'h00);
        rd(ADDR_TYPEA_FLAG, 8'h00);
        i_ext_pin <= 1'b0;
        idle(6);
        rd(ADDR_TYPEA_FLAG, 8'h80);
        @(negedge i_sys_clk);
        chk("frozen flag", 16'h0000, {8'h00, f_rdata});
        wr(ADDR_TYPEA_FLAG, 8'h00);
        wr(ADDR_TYPEA_CTRL, 8'h24);
        rd(ADDR_TYPEA_CTRL, 8'h24);
        @(negedge i_sys_clk);
        chk("frozen ctrl", 16'h0004, {8'h00, f_rdata});
        @(posedge i_sys_clk);
        i_ext_pin <= 1'b1;
        wait_hi(1'b1);
        chk("frozen nmi", 16'h0000, {15'h0000, f_nmi});
        cpu(1'b0, VEC_NMI);
        @(posedge i_sys_clk);
        i_ext_pin <= 1'b0;
        idle(4);
        i_ext_pin <= 1'b1;
        idle(6);
        @(negedge i_sys_clk);
        chk("nmi", 16'h0000, {15'h0000, o_nmi});
        // The edge seen inside the routine must be dropped, not held for later
        cpu(1'b1, 16'h0000);
        chk("nmi", 16'h0000, {15'h0000, o_nmi});
        $display("test type a done");
        end_sim();
    end
endmodule
